// ---- rtl/iqf_map.svh ----
// offsets, field positions, reset values and codes of the command queue front end
`ifndef IQF_MAP_SVH
`define IQF_MAP_SVH

// register byte offsets, one aligned word each
`define IQF_OFF_CTRL     8'h00
`define IQF_OFF_BASE     8'h04
`define IQF_OFF_SIZE     8'h08
`define IQF_OFF_PROD     8'h0C
`define IQF_OFF_CONS     8'h10
`define IQF_OFF_STATUS   8'h14
`define IQF_OFF_CAPS     8'h18

// control and status bit positions, and the control reset value
`define IQF_CTRL_EN      0
`define IQF_CTRL_CHK     1
`define IQF_STAT_ERR     0
`define IQF_CTRL_RST     32'h0000_0002

// queue index geometry
`define IQF_IDX_W        20
`define IQF_QLOG_MAX     5'h13
`define IQF_ENTRY_SHIFT  4

// error codes reported in status
`define IQF_ERR_NONE     2'h0
`define IQF_ERR_ILL      2'h1
`define IQF_ERR_ABT      2'h2

// command field positions within the 128-bit little-endian entry
`define IQF_F_RSVD_LO    8
`define IQF_F_STREAM_SECURE_BIT       10
`define IQF_F_SSV        11
`define IQF_F_SSID_LO    12
`define IQF_F_SID_LO     32
`define IQF_F_ADDR_LO    76
`define IQF_F_MSI_LO     66

`endif

// ---- rtl/iqf_pkg.sv ----
// types of the command queue front end
package iqf_pkg;

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_WAIT, S_ISSUE, S_SYNC, S_ERR} iqf_fsm_t;

  typedef struct packed {
    logic [7:0]  opcode;
    logic        illegal;
    logic        no_effect;
    logic        is_sync;
    logic        stream_sec;
    logic        substream_valid_bit;
    logic [31:0] stream_id;
    logic [19:0] sub_id;
    logic [63:0] addr;
  } iqf_cmd_t;

  typedef struct packed {
    logic         valid;
    logic         abort;
    logic [127:0] data;
  } iqf_mem_rsp_t;

  typedef struct packed {
    logic        empty;
    logic        full;
    logic [19:0] cons_nxt;
    logic [18:0] slot;
  } iqf_qstat_t;

  typedef struct packed {
    iqf_fsm_t    fsm;
    logic [1:0]  dph;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic        en;
    logic        chk;
    logic [31:0] base;
    logic [4:0]  qlog;
    logic [19:0] prod;
    logic [19:0] cons;
    logic        err;
    logic [1:0]  ecode;
    logic [7:0]  lastop;
    iqf_cmd_t    cmd;
    logic        full_seen;
    logic        wake;
    logic [31:0] maddr;
  } iqf_state_t;

endpackage

// ---- rtl/iqf_qstate.sv ----
// circular queue empty, full and next consumer index
`include "iqf_map.svh"
module iqf_qstate (
  input  wire logic [19:0]        prod,
  input  wire logic [19:0]        cons,
  input  wire logic [4:0]         qlog,
  output iqf_pkg::iqf_qstat_t     qs
);

  // mask of the index bits, wrap bit excluded
  function automatic logic [19:0] idx_mask(input logic [4:0] lg);
    idx_mask = (20'h0_0001 << lg) - 20'h0_0001;
  endfunction

  logic [19:0] m1;
  logic [19:0] m2;

  // empty when equal, full when only the wrap bit differs
  always_comb
  begin
    m1          = idx_mask(qlog);
    m2          = {m1[18:0], 1'b1};
    qs.empty    = ((prod ^ cons) & m2) == 20'h0_0000;
    qs.full     = ((prod ^ cons) & m2) == (m2 & ~m1);
    qs.cons_nxt = (cons + 20'h0_0001) & m2;
    qs.slot     = cons[18:0] & m1[18:0];
  end

endmodule

// ---- rtl/iqf_cmd_decode.sv ----
// opcode decode and common field checks for one queue entry
`include "iqf_map.svh"
module iqf_cmd_decode #(
  parameter int NS_SID_W = 16,
  parameter int S_SID_W  = 16,
  parameter int SSID_W   = 8,
  parameter bit SEC_IMPL = 1'b1
) (
  input  wire logic [127:0]       raw,
  input  wire logic               secure_q,
  input  wire logic               chk_rsvd,
  output iqf_pkg::iqf_cmd_t       dec
);

  // opcodes that name a command; all others are reserved
  function automatic logic op_known(input logic [7:0] op);
    op_known = (op >= 8'h01 && op <= 8'h07) ||
               (op >= 8'h10 && op <= 8'h13) || op == 8'h18 || op == 8'h1A ||
               (op >= 8'h20 && op <= 8'h23) || op == 8'h28 || op == 8'h2A ||
               op == 8'h30 || (op >= 8'h50 && op <= 8'h53) || op == 8'h58 ||
               op == 8'h5A || op == 8'h60 ||
               op == 8'h40 || op == 8'h41 || (op >= 8'h44 && op <= 8'h46) ||
               (op >= 8'h80 && op <= 8'h8F);
  endfunction

  // commands carrying a stream and substream identifier
  function automatic logic has_stream(input logic [7:0] op);
    has_stream = (op >= 8'h01 && op <= 8'h05);
  endfunction

  // value wider than the implemented width
  function automatic logic too_wide(input logic [31:0] v, input int w);
    too_wide = (w < 32) && ((v >> w) != 32'h0000_0000);
  endfunction

  logic [7:0]  op;
  logic        stream_secure_bit;
  logic [31:0] sid;
  logic        oor;

  always_comb
  begin
    op             = raw[7:0];
    stream_secure_bit           = raw[`IQF_F_STREAM_SECURE_BIT];
    sid            = raw[`IQF_F_SID_LO +: 32];
    dec.opcode     = op;
    dec.is_sync    = op == 8'h46;
    dec.substream_valid_bit        = raw[`IQF_F_SSV];
    dec.sub_id     = raw[`IQF_F_SSV] ? raw[`IQF_F_SSID_LO +: 20] : 20'h0_0000;
    dec.stream_sec = secure_q && SEC_IMPL && stream_secure_bit;
    dec.stream_id  = sid;
    // address layout by command class
    if (op == 8'h2A || op == 8'h5A)
      dec.addr = {12'h000, raw[`IQF_F_ADDR_LO +: 40], 12'h000};
    else if (op == 8'h46)
      dec.addr = {12'h000, raw[`IQF_F_MSI_LO +: 50], 2'b00};
    else
      dec.addr = {raw[`IQF_F_ADDR_LO +: 52], 12'h000};
    // reserved opcode, stream-secure on the open queue, or checked reserved bits
    dec.illegal = !op_known(op) ||
                  (!secure_q && stream_secure_bit) ||
                  (chk_rsvd && raw[`IQF_F_RSVD_LO +: 2] != 2'b00);
    // out-of-range identifiers give no effect
    oor = has_stream(op) &&
          (too_wide(sid, dec.stream_sec ? S_SID_W : NS_SID_W) ||
           (dec.substream_valid_bit && too_wide({12'h000, dec.sub_id}, SSID_W)));
    dec.no_effect = oor;
  end

endmodule

// ---- rtl/iqf_frontend.sv ----
// command queue front end: register slave, entry fetch, decode and consume
// Functional notes
// - entries are 16-byte records, opcode first byte
// - opcodes 0x01-0x07 prefetch and config invalidation
// - translation invalidation opcodes, secure and open
// - 0x40, 0x41, 0x44-0x46 accepted, others reserved raise illegal
// - never fetch at or past producer index
// - run only when non-empty, enabled, error-free
// - wake-up event when full queue becomes non-full; here only if CONS or STATUS was read while full
// - bad parameters or reserved bits raise illegal
// - illegal error wins over ignoring a command
// - read abort on fetch raises abort error
// - stop at first error, index on failing entry
// - consumed once consumer index passes slot
// - sync waits for all earlier commands done
// - reserved fields checked or all ignored
// - substream valid bit qualifies substream identifier
// - stream-secure bit selects security on secure queue
// - stream-secure set on open queue is illegal
// - virtual addresses carry bits 63:12 only
// - physical addresses bits 51:12, interrupt 51:2
// - out-of-range parameter makes command no effect
// - identifier ranges follow implemented widths
//
// The address map and the AHB-Lite register port were decided locally.
`include "iqf_map.svh"
module iqf_frontend #(
  parameter bit WAKE_CAP  = 1'b1,
  parameter bit SEC_IMPL  = 1'b1,
  parameter bit SECURE_Q  = 1'b0,
  parameter int NS_SID_W  = 16,
  parameter int S_SID_W   = 16,
  parameter int SSID_W    = 8
) (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  output logic                        mem_req,
  output logic [31:0]                 mem_addr,
  input  wire logic                   mem_gnt,
  input  wire iqf_pkg::iqf_mem_rsp_t  mem_rsp,
  output logic                        cmd_valid,
  output iqf_pkg::iqf_cmd_t           cmd,
  input  wire logic                   cmd_ready,
  input  wire logic                   backend_idle,
  output logic                        wakeup_event,
  output logic                        queue_error
);

  iqf_pkg::iqf_state_t st_r;
  iqf_pkg::iqf_state_t st_nxt;
  iqf_pkg::iqf_qstat_t qs;
  iqf_pkg::iqf_cmd_t   dec;
  logic                ahb_take;
  logic                dp_do;
  logic [31:0]         rd_val;
  logic                advance;

  // queue occupancy from producer and consumer indexes
  iqf_qstate u_qstate (
    .prod (st_r.prod),
    .cons (st_r.cons),
    .qlog (st_r.qlog),
    .qs   (qs)
  );

  // decode of the returning entry
  iqf_cmd_decode #(
    .NS_SID_W (NS_SID_W),
    .S_SID_W  (S_SID_W),
    .SSID_W   (SSID_W),
    .SEC_IMPL (SEC_IMPL)
  ) u_decode (
    .raw      (mem_rsp.data),
    .secure_q (SECURE_Q),
    .chk_rsvd (st_r.chk),
    .dec      (dec)
  );

  // entry address of a slot
  function automatic logic [31:0] slot_addr(input logic [31:0] base, input logic [18:0] slot);
    slot_addr = base + {9'h000, slot, 4'h0};
  endfunction

  // readback mux for the data-phase address
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (st_r.addr)
      `IQF_OFF_CTRL:   rd_val = {30'h0000_0000, st_r.chk, st_r.en};
      `IQF_OFF_BASE:   rd_val = st_r.base;
      `IQF_OFF_SIZE:   rd_val = {27'h000_0000, st_r.qlog};
      `IQF_OFF_PROD:   rd_val = {12'h000, st_r.prod};
      `IQF_OFF_CONS:   rd_val = {12'h000, st_r.cons};
      `IQF_OFF_STATUS: rd_val = {16'h0000, st_r.lastop, 1'b0, qs.full, qs.empty,
                                 st_r.fsm != iqf_pkg::S_IDLE, 1'b0, st_r.ecode, st_r.err};
      `IQF_OFF_CAPS:   rd_val = {8'(SSID_W), 8'(S_SID_W), 8'(NS_SID_W),
                                 5'h00, SECURE_Q, SEC_IMPL, WAKE_CAP};
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  // bus address phase acceptance and data-phase action
  assign ahb_take = hsel && htrans[1] && hready;
  assign dp_do    = st_r.dph == 2'h1;

  // next state of registers, bus slave and command engine
  always_comb
  begin
    st_nxt      = st_r;
    st_nxt.wake = 1'b0;
    advance     = 1'b0;

    // bus: one wait cycle, then answer
    if (dp_do)
    begin
      st_nxt.dph = 2'h2;
      if (st_r.wr)
      begin
        unique case (st_r.addr)
          `IQF_OFF_CTRL:
          begin
            st_nxt.en  = hwdata[`IQF_CTRL_EN];
            st_nxt.chk = hwdata[`IQF_CTRL_CHK];
          end
          `IQF_OFF_BASE:   st_nxt.base = {hwdata[31:4], 4'h0};
          `IQF_OFF_SIZE:   st_nxt.qlog = (hwdata[4:0] > `IQF_QLOG_MAX) ? `IQF_QLOG_MAX : hwdata[4:0];
          `IQF_OFF_PROD:   st_nxt.prod = hwdata[19:0];
          `IQF_OFF_STATUS:
          begin
            if (hwdata[`IQF_STAT_ERR])
            begin
              st_nxt.err   = 1'b0;
              st_nxt.ecode = `IQF_ERR_NONE;
            end
          end
          default:         st_nxt.dph = 2'h2;
        endcase
      end
      else
      begin
        st_nxt.rdata = rd_val;
        // software has looked at a full queue
        if (qs.full && (st_r.addr == `IQF_OFF_CONS || st_r.addr == `IQF_OFF_STATUS))
          st_nxt.full_seen = 1'b1;
      end
    end
    else if (st_r.dph == 2'h2 || st_r.dph == 2'h0)
    begin
      st_nxt.dph = 2'h0;
    end
    if (ahb_take && st_r.dph != 2'h1)
    begin
      st_nxt.dph  = 2'h1;
      st_nxt.wr   = hwrite;
      st_nxt.addr = {haddr[7:2], 2'b00};
    end

    // command engine
    unique case (st_r.fsm)
      iqf_pkg::S_IDLE:
      begin
        if (st_r.en && !st_r.err && !qs.empty)
        begin
          st_nxt.maddr = slot_addr(st_r.base, qs.slot);
          st_nxt.fsm   = iqf_pkg::S_FETCH;
        end
      end
      iqf_pkg::S_FETCH:
      begin
        if (mem_gnt)
          st_nxt.fsm = iqf_pkg::S_WAIT;
      end
      iqf_pkg::S_WAIT:
      begin
        if (mem_rsp.valid)
        begin
          st_nxt.cmd    = dec;
          st_nxt.lastop = dec.opcode;
          if (mem_rsp.abort)
          begin
            st_nxt.err   = 1'b1;
            st_nxt.ecode = `IQF_ERR_ABT;
            st_nxt.fsm   = iqf_pkg::S_ERR;
          end
          else if (dec.illegal)
          begin
            st_nxt.err   = 1'b1;
            st_nxt.ecode = `IQF_ERR_ILL;
            st_nxt.fsm   = iqf_pkg::S_ERR;
          end
          else if (dec.no_effect)
          begin
            advance    = 1'b1;
            st_nxt.fsm = iqf_pkg::S_IDLE;
          end
          else if (dec.is_sync)
            st_nxt.fsm = iqf_pkg::S_SYNC;
          else
            st_nxt.fsm = iqf_pkg::S_ISSUE;
        end
      end
      iqf_pkg::S_SYNC:
      begin
        if (backend_idle)
          st_nxt.fsm = iqf_pkg::S_ISSUE;
      end
      iqf_pkg::S_ISSUE:
      begin
        if (cmd_ready)
        begin
          advance    = 1'b1;
          st_nxt.fsm = iqf_pkg::S_IDLE;
        end
      end
      iqf_pkg::S_ERR:
      begin
        if (!st_nxt.err)
          st_nxt.fsm = iqf_pkg::S_IDLE;
      end
    endcase

    // consume: step the index, wake a waiter if it was seen full
    if (advance)
    begin
      st_nxt.cons = qs.cons_nxt;
      if (qs.full && st_r.full_seen)
      begin
        st_nxt.wake      = WAKE_CAP;
        st_nxt.full_seen = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r       <= '0;
      st_r.fsm   <= iqf_pkg::S_IDLE;
      st_r.chk   <= 1'((`IQF_CTRL_RST >> `IQF_CTRL_CHK) & 32'h0000_0001);
    end
    else
      st_r <= st_nxt;
  end

  // outputs
  assign hreadyout    = st_r.dph != 2'h1;
  assign hrdata       = st_r.rdata;
  assign hresp        = 1'b0;
  assign mem_req      = st_r.fsm == iqf_pkg::S_FETCH;
  assign mem_addr     = st_r.maddr;
  assign cmd_valid    = st_r.fsm == iqf_pkg::S_ISSUE;
  assign cmd          = st_r.cmd;
  assign wakeup_event = st_r.wake;
  assign queue_error  = st_r.err;

endmodule

// ---- bench/iqf_frontend_props.sv ----
// concurrent checks on the command queue front end ports
module iqf_chk (
  input wire logic                  mclk,
  input wire logic                  reset,
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hready,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  mem_req,
  input wire logic [31:0]           mem_addr,
  input wire logic                  mem_gnt,
  input wire iqf_pkg::iqf_mem_rsp_t mem_rsp,
  input wire logic                  cmd_valid,
  input wire iqf_pkg::iqf_cmd_t     cmd,
  input wire logic                  cmd_ready,
  input wire logic                  backend_idle,
  input wire logic                  wakeup_event,
  input wire logic                  queue_error
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // address phase taken, then one wait cycle
  sequence s_taken;
    hsel && htrans[1] && hready;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  // bus, fetch and issue handshakes
  a_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_dphase_two: assert property (s_taken |=> s_one_wait)
    else $error("data phase not two cycles");
  a_fetch_hold: assert property (mem_req && !mem_gnt |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped or moved");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
    else $error("command changed before accept");

  // error behaviour and decoded fields
  a_err_stops: assert property (queue_error |-> !mem_req && !cmd_valid)
    else $error("activity while queue error set");
  a_abort_err: assert property (mem_rsp.valid && mem_rsp.abort |-> ##[1:2] queue_error)
    else $error("abort not reported");
  a_issue_legal: assert property (cmd_valid |-> !cmd.illegal && !cmd.stream_sec)
    else $error("illegal command issued");
  a_sync_after: assert property ($rose(cmd_valid) && cmd.is_sync |-> $past(backend_idle))
    else $error("sync issued before back end idle");
  a_wake_pulse: assert property (wakeup_event |=> !wakeup_event)
    else $error("wake-up longer than one cycle");
  a_va_low: assert property (cmd_valid && !cmd.is_sync |-> cmd.addr[11:0] == 12'h000)
    else $error("address low bits not zero");
endmodule

bind iqf_frontend iqf_chk chk_u (.mclk(mclk), .reset(reset), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
  .mem_rsp(mem_rsp), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .backend_idle(backend_idle),
  .wakeup_event(wakeup_event), .queue_error(queue_error));

// ---- bench/iqf_mem_model.sv ----
// memory holding the queue entries, and a stalling back end
module iqf_mem_model (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 mem_req,
  input  wire logic [31:0]          mem_addr,
  output logic                      mem_gnt,
  output iqf_pkg::iqf_mem_rsp_t     mem_rsp,
  output logic                      cmd_ready,
  output logic                      backend_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [127:0] mem [4];
  logic         abort_on = 1'b0;
  logic [1:0]   abort_slot;
  logic         pend;
  logic [1:0]   dly;
  logic [1:0]   slot;
  logic [31:0]  rnd;
  int           seed = 20;

  // random grant, delayed one-beat answer, random back end stalls
  always @(posedge mclk)
  begin
    rnd = $random(seed);
    cmd_ready <= rnd[3];
    backend_idle <= rnd[4] | rnd[5];
    if (reset)
    begin
      mem_gnt <= 1'b0;
      mem_rsp <= '0;
      pend <= 1'b0;
      dly <= 2'd0;
    end
    else if (mem_req && mem_gnt)
    begin
      mem_gnt <= 1'b0;
      pend <= 1'b1;
      dly <= rnd[1:0];
      slot <= mem_addr[5:4];
      mem_rsp <= {1'b0, 1'b0, ~mem_rsp.data}; // no stale entry between beats
    end
    else if (pend && dly == 2'd0)
    begin
      pend <= 1'b0;
      mem_rsp <= {1'b1, abort_on && slot == abort_slot, mem[slot]};
    end
    else
    begin
      dly <= dly - 2'd1;
      mem_gnt <= mem_req && rnd[2];
      mem_rsp <= {1'b0, 1'b0, ~mem_rsp.data};
    end
  end
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the command queue front end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk = 1'b0;
  logic                  reset = 1'b1;
  logic                  hsel = 1'b0;
  logic                  hwrite = 1'b0;
  logic [1:0]            htrans = 2'h0;
  logic [2:0]            hsize = 3'h2;
  logic [31:0]           haddr = 32'h0000_0000;
  logic [31:0]           hwdata = 32'h0000_0000;
  logic [31:0]           q;
  logic [31:0]           hrdata, mem_addr;
  logic                  hreadyout, hresp, mem_req, mem_gnt, cmd_valid, cmd_ready;
  logic                  backend_idle, wakeup_event, queue_error;
  iqf_pkg::iqf_mem_rsp_t mem_rsp;
  iqf_pkg::iqf_cmd_t     cmd;
  int                    err_total = 0;
  int                    samples_checked = 0;
  int                    seed = 20;
  int                    cyc = 0;
  int                    p = 0;
  int                    n;

  always #2.5 mclk = ~mclk;

  iqf_frontend dut_u (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt), .mem_rsp(mem_rsp), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .backend_idle(backend_idle), .wakeup_event(wakeup_event),
    .queue_error(queue_error));
  iqf_mem_model mem_u (.mclk(mclk), .reset(reset), .mem_req(mem_req), .mem_addr(mem_addr), .mem_gnt(mem_gnt),
    .mem_rsp(mem_rsp), .cmd_ready(cmd_ready), .backend_idle(backend_idle));

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one single-word bus transfer, read data left in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, q & m, e);
  endtask

  // opcodes that the decoder must accept
  function automatic logic ok(input logic [7:0] o);
    return o inside {[1:7], [8'h10:8'h13], 8'h18, 8'h1A, [8'h20:8'h23], 8'h28, 8'h2A, 8'h30, 8'h40, 8'h41,
      [8'h44:8'h46], [8'h50:8'h53], 8'h58, 8'h5A, 8'h60, [8'h80:8'h8F]};
  endfunction

  // write one entry, then advance the producer index
  task automatic put(input logic [7:0] op, input logic [2:0] bad, input logic [31:0] sid);
    mem_u.mem[p % 4] = {64'h0000_0000_0000_0000, sid, 20'h0_0000, 1'b0, bad, op};
    p = p + 1;
    bus(1'b1, 8'h0C, 32'(p % 8));
  endtask

  task automatic wacc;
    do @(posedge mclk); while (!(cmd_valid === 1'b1 && cmd_ready === 1'b1) && queue_error !== 1'b1);
  endtask

  // one command through the model: issue, or error then repair
  task automatic run(input logic [7:0] op, input logic [2:0] bad, input logic ab);
    logic [31:0] sid;
    sid = $random(seed) & 32'h0000_FFFF;
    mem_u.abort_on = ab;
    mem_u.abort_slot = 2'(p % 4);
    put(op, bad, sid);
    wacc();
    if (ok(op) && bad == 3'b000 && !ab)
    begin
      chk("opcode", cmd.opcode, op);
      if (op == 8'h01)
        chk("stream id", cmd.stream_id, sid);
    end
    else
    begin
      chk("error", queue_error, 1'b1);
      rd(8'h14, 32'h0000_0007, ab ? 32'h0000_0005 : 32'h0000_0003, "status");
      rd(8'h10, 32'hFFFF_FFFF, 32'((p - 1) % 8), "cons held");
      mem_u.abort_on = 1'b0;
      mem_u.mem[(p - 1) % 4] = 128'(8'h10);
      bus(1'b1, 8'h14, 32'h0000_0001);
      wacc();
      chk("retry opcode", cmd.opcode, 8'h10);
    end
    rd(8'h10, 32'hFFFF_FFFF, 32'(p % 8), "cons");
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_total++;
      results();
    end
  end

  // main sequence
  initial
  begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    rd(8'h00, 32'hFFFF_FFFF, 32'h0000_0002, "ctrl reset");
    rd(8'h18, 32'hFFFF_FFFF, 32'h0810_1003, "caps");
    rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    bus(1'b1, 8'h10, 32'h0000_0005);
    rd(8'h10, 32'hFFFF_FFFF, 32'h0000_0000, "cons read only");
    bus(1'b1, 8'h04, 32'h0000_1000);
    bus(1'b1, 8'h08, 32'h0000_0002);
    bus(1'b1, 8'h00, 32'h0000_0003);
    for (n = 0; n < 256; n++)
      run(8'(n), 3'b000, 1'b0);
    run(8'h10, 3'b001, 1'b0);
    run(8'h46, 3'b010, 1'b0);
    run(8'h01, 3'b100, 1'b0);
    run(8'h46, 3'b000, 1'b1);
    run(8'h00, 3'b000, 1'b1);
    bus(1'b1, 8'h00, 32'h0000_0002);
    repeat (4) put(8'h10, 3'b000, 32'h0000_0000);
    rd(8'h14, 32'h0000_0040, 32'h0000_0040, "full");
    rd(8'h10, 32'hFFFF_FFFF, 32'((p - 4) % 8), "cons disabled");
    n = 0;
    bus(1'b1, 8'h00, 32'h0000_0003);
    repeat (100)
    begin
      @(posedge mclk);
      n = n + (wakeup_event === 1'b1);
    end
    chk("wakeups", n, 1);
    rd(8'h10, 32'hFFFF_FFFF, 32'(p % 8), "cons drained");
    results();
  end
endmodule
